/* scw_capture_qualify.sv */
// Purpose: Detects SYSREF transitions and drops those that fall inside the skew windows.
// Assumes: sysref_in and the skew and phase measurements are synchronous to pclk.
// Notes: Outputs are registered, one cycle after the transition is seen.
`timescale 1ns/1ps
module scw_capture_qualify (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Configuration.
    input wire logic enable,
    input wire logic [scw_pkg::WIN_W-1:0] neg_window,
    input wire logic [scw_pkg::WIN_W-1:0] pos_window,
    // Measurement.
    input wire logic sysref_in,
    input wire logic signed [scw_pkg::SKEW_W-1:0] sysref_skew,
    input wire logic [scw_pkg::PHASE_W-1:0] div_phase_in,
    // Qualified capture.
    output logic cap_pulse,
    output logic cap_early,
    output logic cap_late,
    output logic [scw_pkg::SKEW_W-1:0] cap_mag,
    output logic [scw_pkg::PHASE_W-1:0] cap_phase
);
    import scw_pkg::*;

    logic sysref_q;
    logic edge_seen;
    logic [SKEW_W-1:0] mag;
    logic ignored;

    ////////////////////////////////////////////////////////////////////////////
    // A transition exactly on the sample clock (skew zero) is taken whenever enable is high.
    assign edge_seen = enable && sysref_in && !sysref_q;
    assign mag = sysref_skew[SKEW_W-1] ? SKEW_W'(-sysref_skew) : SKEW_W'(sysref_skew);

    always_comb begin
        ignored = 1'b0;
        if (sysref_skew[SKEW_W-1]) begin
            ignored = mag <= {2'b00, neg_window}; // see RULE_01, see RULE_02
        end else if (sysref_skew != '0) begin
            ignored = mag <= {2'b00, pos_window}; // see RULE_03, see RULE_04
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysref_q <= 1'b0;
        end else begin
            sysref_q <= sysref_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_pulse <= 1'b0;
            cap_early <= 1'b0;
            cap_late <= 1'b0;
            cap_mag <= '0;
            cap_phase <= PHASE_INIT;
        end else begin
            cap_pulse <= edge_seen && !ignored; // see RULE_13
            cap_early <= sysref_skew[SKEW_W-1];
            cap_late <= !sysref_skew[SKEW_W-1] && (sysref_skew != '0);
            cap_mag <= mag;
            cap_phase <= div_phase_in;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_window_drops_edge: assert property (edge_seen && ignored |=> !cap_pulse) // see RULE_13
        else $error("edge inside skew window was captured");
    chk_exact_edge_taken: assert property (edge_seen && sysref_skew == '0 |=> cap_pulse) // see RULE_02
        else $error("exact edge was not captured");
    chk_late_outside: assert property (edge_seen && !sysref_skew[SKEW_W-1] && mag > {2'b00, pos_window}
        |=> cap_pulse && cap_late) // see RULE_04
        else $error("late edge outside window was not captured");

endmodule

/* scw_pkg.sv */
// Purpose: Shared constants and types for the SYSREF capture window and status block.
// Assumes: Register indices are word indices; the APB byte address is four times the index.
// Notes: Each register holds eight bits in the low byte lane; upper bits read as zero.
package scw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Bus geometry.
    localparam int PADDR_W = 14;
    localparam int IDX_W = 12;
    localparam int PDATA_W = 32;
    localparam int REG_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices (byte address = index * 4).
    localparam logic [IDX_W-1:0] IDX_CTRL1 = 12'h120;
    localparam logic [IDX_W-1:0] IDX_SKEW_WINDOW = 12'h122;
    localparam logic [IDX_W-1:0] IDX_TS_DELAY = 12'h123;
    localparam logic [IDX_W-1:0] IDX_SETUP_HOLD = 12'h128;
    localparam logic [IDX_W-1:0] IDX_DIV_PHASE = 12'h129;
    localparam logic [IDX_W-1:0] IDX_CAPTURE_COUNT = 12'h12a;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h130;
    localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 12'h131;
    localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 12'h132;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and widths.
    localparam int FLAG_RESET_BIT = 6;
    localparam int MODE_LSB = 1;
    localparam int MODE_W = 2;
    localparam int NEG_WIN_LSB = 2;
    localparam int POS_WIN_LSB = 0;
    localparam int WIN_W = 2;
    localparam int TS_DELAY_LSB = 0;
    localparam int TS_DELAY_W = 7;
    localparam int SETUP_LSB = 0;
    localparam int HOLD_LSB = 4;
    localparam int STAT_W = 4;
    localparam int PHASE_W = 4;
    localparam int COUNT_W = 8;
    localparam int SKEW_W = 4;
    localparam int IRQ_W = 3;
    localparam int IRQ_CAPTURE_BIT = 0;
    localparam int IRQ_SETUP_BIT = 1;
    localparam int IRQ_HOLD_BIT = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and counts.
    localparam logic FLAG_RESET_INIT = 1'b0;
    localparam logic [MODE_W-1:0] MODE_INIT = 2'h0;
    localparam logic [WIN_W-1:0] WIN_INIT = 2'h0;
    localparam logic [TS_DELAY_W-1:0] TS_DELAY_INIT = 7'h40;
    localparam logic [STAT_W-1:0] STAT_INIT = 4'h0;
    localparam logic [PHASE_W-1:0] PHASE_INIT = 4'h0;
    localparam logic [COUNT_W-1:0] COUNT_INIT = 8'h00;
    localparam logic [COUNT_W-1:0] COUNT_STEP = 8'h01;
    localparam logic [IRQ_W-1:0] IRQ_INIT = 3'h0;
    localparam int TS_DELAY_DEPTH = 128;

    ////////////////////////////////////////////////////////////////////////////
    // Capture modes.
    typedef enum logic [MODE_W-1:0] {
        SCW_MODE_DISABLED = 2'b00,
        SCW_MODE_CONTINUOUS = 2'b01,
        SCW_MODE_NSHOT = 2'b10
    } scw_mode_t;

endpackage

/* scw_sysref_src.sv */
// Purpose: Behavioural SYSREF source for the capture window bench.
// Assumes: fire is raised for one cycle by the bench, just after a rising edge.
// Notes: Between pulses skew and phase toggle, so a stale value cannot pass for a live one.
`timescale 1ns/1ps
module scw_sysref_src (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Request from the bench.
    input wire logic fire,
    input wire logic [3:0] req_skew,
    input wire logic [3:0] req_phase,
    // Lines toward the device.
    output logic sysref_in,
    output logic signed [scw_pkg::SKEW_W-1:0] sysref_skew,
    output logic [scw_pkg::PHASE_W-1:0] div_phase_in
);
    import scw_pkg::*;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysref_in <= 1'b0;
            sysref_skew <= 4'h0;
            div_phase_in <= 4'h0;
        end else if (fire && !sysref_in) begin
            sysref_in <= 1'b1;
            sysref_skew <= req_skew;
            div_phase_in <= req_phase;
        end else begin
            sysref_in <= 1'b0;
            sysref_skew <= ~sysref_skew;
            div_phase_in <= ~div_phase_in;
        end
    end
endmodule

/* scw_sysref_window.sv */
// Purpose: APB register block that qualifies SYSREF captures and reports their status.
// Assumes: pclk is the sample clock; SYSREF, skew and divider phase arrive synchronous to it.
// Notes: Zero wait state slave; read data is latched in the setup cycle.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: Two-bit negative skew window in sample clocks.
// RULE_02: Negative code zero exact; others tolerate 1-3.
// RULE_03: Separate two-bit positive skew window setting.
// RULE_04: Positive code zero exact; others tolerate 1-3.
// RULE_05: Timestamp delay 0 to 127, resets 64.
// RULE_06: Latch four-bit divider phase on each capture.
// RULE_07: Eight-bit read-only capture counter increments.
// RULE_08: Counter wraps from 255 to zero.
// RULE_09: Flag reset clears and holds counter zero.
// RULE_10: Software reads counter only while mode disabled.
// RULE_11: Flag reset holds setup/hold flags cleared.
// RULE_12: Software disables mode before changing polarity.
// RULE_13: Only transitions outside windows update status.
// RULE_14: Four-bit setup and hold status fields.
module scw_sysref_window (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic [scw_pkg::PADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [scw_pkg::PDATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [scw_pkg::PDATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // SYSREF capture path.
    input wire logic sysref_in,
    input wire logic signed [scw_pkg::SKEW_W-1:0] sysref_skew,
    input wire logic [scw_pkg::PHASE_W-1:0] div_phase_in,
    output logic sysref_timestamp,
    // Interrupt.
    output logic irq
);
    import scw_pkg::*;

    logic flag_reset;
    logic [MODE_W-1:0] mode;
    logic [WIN_W-1:0] neg_window;
    logic [WIN_W-1:0] pos_window;
    logic [TS_DELAY_W-1:0] ts_delay;
    logic [STAT_W-1:0] setup_status;
    logic [STAT_W-1:0] hold_status;
    logic [PHASE_W-1:0] div_phase;
    logic [COUNT_W-1:0] capture_count;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic [IDX_W-1:0] idx;
    logic access;
    logic wr_en;
    logic hit;
    logic [REG_W-1:0] next_rdata;
    logic capture_enable;
    logic cap_pulse;
    logic cap_early;
    logic cap_late;
    logic [SKEW_W-1:0] cap_mag;
    logic [PHASE_W-1:0] cap_phase;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode.
    assign idx = paddr[PADDR_W-1:2];
    assign access = psel && penable;
    assign wr_en = access && pwrite && pstrb[0];
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    always_comb begin
        case (idx)
            IDX_CTRL1, IDX_SKEW_WINDOW, IDX_TS_DELAY, IDX_SETUP_HOLD, IDX_DIV_PHASE,
            IDX_CAPTURE_COUNT, IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE: begin
                hit = 1'b1;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_rdata = '0;
        case (idx)
            IDX_CTRL1: begin
                next_rdata[FLAG_RESET_BIT] = flag_reset;
                next_rdata[MODE_LSB +: MODE_W] = mode;
            end
            IDX_SKEW_WINDOW: begin
                next_rdata[NEG_WIN_LSB +: WIN_W] = neg_window;
                next_rdata[POS_WIN_LSB +: WIN_W] = pos_window;
            end
            IDX_TS_DELAY: begin
                next_rdata[TS_DELAY_LSB +: TS_DELAY_W] = ts_delay;
            end
            IDX_SETUP_HOLD: begin
                next_rdata[SETUP_LSB +: STAT_W] = setup_status; // see RULE_14
                next_rdata[HOLD_LSB +: STAT_W] = hold_status; // see RULE_14
            end
            IDX_DIV_PHASE: begin
                next_rdata[PHASE_W-1:0] = div_phase;
            end
            IDX_CAPTURE_COUNT: begin
                next_rdata = capture_count; // see RULE_07
            end
            IDX_IRQ_STATUS: begin
                next_rdata[IRQ_W-1:0] = irq_status;
            end
            IDX_IRQ_ENABLE: begin
                next_rdata[IRQ_W-1:0] = irq_enable;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Latching in the setup cycle keeps prdata a flop and stable through the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {{(PDATA_W-REG_W){1'b0}}, next_rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written configuration.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reset <= FLAG_RESET_INIT;
            mode <= MODE_INIT;
        end else if (wr_en && idx == IDX_CTRL1) begin
            flag_reset <= pwdata[FLAG_RESET_BIT];
            mode <= pwdata[MODE_LSB +: MODE_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neg_window <= WIN_INIT;
            pos_window <= WIN_INIT;
        end else if (wr_en && idx == IDX_SKEW_WINDOW) begin
            neg_window <= pwdata[NEG_WIN_LSB +: WIN_W]; // see RULE_01
            pos_window <= pwdata[POS_WIN_LSB +: WIN_W]; // see RULE_03
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ts_delay <= TS_DELAY_INIT; // see RULE_05
        end else if (wr_en && idx == IDX_TS_DELAY) begin
            ts_delay <= pwdata[TS_DELAY_LSB +: TS_DELAY_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_enable <= IRQ_INIT;
        end else if (wr_en && idx == IDX_IRQ_ENABLE) begin
            irq_enable <= pwdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture qualification and timestamp.
    // Software is expected to disable capture before touching polarity or reading the count.
    assign capture_enable = mode != SCW_MODE_DISABLED; // see RULE_12, see RULE_10

    scw_capture_qualify u_qualify (
        .pclk(pclk),
        .presetn(presetn),
        .enable(capture_enable),
        .neg_window(neg_window),
        .pos_window(pos_window),
        .sysref_in(sysref_in),
        .sysref_skew(sysref_skew),
        .div_phase_in(div_phase_in),
        .cap_pulse(cap_pulse),
        .cap_early(cap_early),
        .cap_late(cap_late),
        .cap_mag(cap_mag),
        .cap_phase(cap_phase)
    );

    scw_ts_delay #(
        .DEPTH(TS_DELAY_DEPTH),
        .SEL_W(TS_DELAY_W)
    ) u_ts_delay (
        .pclk(pclk),
        .presetn(presetn),
        .in_pulse(cap_pulse),
        .delay_sel(ts_delay),
        .out_pulse(sysref_timestamp)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Capture status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_count <= COUNT_INIT;
        end else if (flag_reset) begin
            capture_count <= COUNT_INIT; // see RULE_09
        end else if (cap_pulse) begin
            capture_count <= capture_count + COUNT_STEP; // see RULE_07, see RULE_08
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_phase <= PHASE_INIT;
        end else if (cap_pulse) begin
            div_phase <= cap_phase; // see RULE_06
        end
    end

    // Setup reports how many clocks early, hold how many late, of the last capture.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_status <= STAT_INIT;
            hold_status <= STAT_INIT;
        end else if (flag_reset) begin
            setup_status <= STAT_INIT; // see RULE_11
            hold_status <= STAT_INIT; // see RULE_11
        end else if (cap_pulse) begin
            setup_status <= cap_early ? cap_mag : STAT_INIT; // see RULE_14, see RULE_13
            hold_status <= cap_late ? cap_mag : STAT_INIT; // see RULE_14, see RULE_13
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts: a set in the same cycle as a clear wins.
    always_comb begin
        irq_event = '0;
        irq_event[IRQ_CAPTURE_BIT] = cap_pulse && !flag_reset;
        irq_event[IRQ_SETUP_BIT] = cap_pulse && cap_early && !flag_reset; // see RULE_11
        irq_event[IRQ_HOLD_BIT] = cap_pulse && cap_late && !flag_reset; // see RULE_11
    end

    assign irq_clear = (wr_en && idx == IDX_IRQ_CLEAR) ? pwdata[IRQ_W-1:0] : IRQ_INIT;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= IRQ_INIT;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end

    assign irq = |(irq_status & irq_enable);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_capture_counted;
        cap_pulse && !flag_reset;
    endsequence

    sequence s_write_ts_delay;
        wr_en && idx == IDX_TS_DELAY;
    endsequence

    chk_count_increment: assert property (s_capture_counted |=> // see RULE_07
        capture_count == COUNT_W'($past(capture_count) + COUNT_STEP))
        else $error("capture count did not step by one");
    chk_count_wraps: assert property (s_capture_counted ##0 capture_count == 8'hff |=> // see RULE_08
        capture_count == COUNT_INIT)
        else $error("capture count did not wrap to zero");
    chk_count_held_zero: assert property (flag_reset[*2] |-> capture_count == COUNT_INIT) // see RULE_09
        else $error("capture count not held at zero");
    chk_flags_held_clear: assert property (flag_reset |=> setup_status == STAT_INIT // see RULE_11
        && hold_status == STAT_INIT && (!irq_status[IRQ_SETUP_BIT] || $past(irq_status[IRQ_SETUP_BIT])))
        else $error("setup or hold flag set under flag reset");
    chk_phase_latched: assert property (cap_pulse |=> div_phase == $past(cap_phase)) // see RULE_06
        else $error("divider phase not latched on capture");
    chk_idle_stable: assert property (!cap_pulse && !flag_reset |=> $stable(capture_count)) // see RULE_13
        else $error("capture count moved without a capture");
    chk_setup_reported: assert property (s_capture_counted ##0 cap_early |=> // see RULE_14
        setup_status == $past(cap_mag) && hold_status == STAT_INIT)
        else $error("setup status does not match early capture");
    chk_ts_delay_write: assert property (s_write_ts_delay |=> // see RULE_05
        ts_delay == $past(pwdata[TS_DELAY_LSB +: TS_DELAY_W]))
        else $error("timestamp delay write lost");
    chk_irq_set_wins: assert property (s_capture_counted ##0 irq_clear[IRQ_CAPTURE_BIT] |=>
        irq_status[IRQ_CAPTURE_BIT] && (!irq_enable[IRQ_CAPTURE_BIT] || irq))
        else $error("capture event lost against clear");
    chk_apb_unmapped: assert property (access && !hit |-> pslverr && pready)
        else $error("unmapped access not flagged");

endmodule

/* scw_ts_delay.sv */
// Purpose: Delays the qualified capture pulse by a programmable number of cycles.
// Assumes: The delay setting changes only while captures are idle.
// Notes: Output appears delay plus one cycles after the input pulse.
`timescale 1ns/1ps
module scw_ts_delay #(
    parameter int DEPTH = scw_pkg::TS_DELAY_DEPTH,
    parameter int SEL_W = scw_pkg::TS_DELAY_W
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pulse path.
    input wire logic in_pulse,
    input wire logic [SEL_W-1:0] delay_sel,
    output logic out_pulse
);
    import scw_pkg::*;

    logic [DEPTH-1:0] line;
    logic [SEL_W-1:0] tap;

    assign tap = delay_sel - SEL_W'(1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line <= '0;
        end else begin
            line <= {line[DEPTH-2:0], in_pulse};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_pulse <= 1'b0;
        end else if (delay_sel == '0) begin
            out_pulse <= in_pulse; // see RULE_05
        end else begin
            out_pulse <= line[tap]; // see RULE_05
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_delay_zero: assert property (in_pulse && delay_sel == '0 |=> out_pulse) // see RULE_05
        else $error("zero delay pulse missing");
    chk_delay_two: assert property (in_pulse && delay_sel == SEL_W'(2) && $stable(delay_sel)
        |=> ##2 out_pulse) // see RULE_05
        else $error("two cycle delay pulse missing");

endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the SYSREF capture window block.
// Assumes: Zero wait state APB slave; the bench still waits on pready.
// Notes: The capture count is only read with the mode disabled.
`timescale 1ns/1ps
module tb_top;
    import scw_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [PADDR_W-1:0] paddr = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [PDATA_W-1:0] pwdata = '0, prdata, r;
    logic [3:0] pstrb = 4'h0, wstrb = 4'hf, req_skew = 4'h0, req_phase = 4'h0;
    logic pready, pslverr, e, fire = 1'b0;
    logic sysref_in, sysref_timestamp, irq;
    logic signed [SKEW_W-1:0] sysref_skew;
    logic [PHASE_W-1:0] div_phase_in;
    logic [7:0] cnt = 8'h00, exp_st = 8'h00, exp_ph = 8'h00, mv;
    logic [8:0] x;
    logic [31:0] seed = 32'h75a9_f6e2;
    int n_mismatch = 0, n_tests = 0, ng, ps, sk;

    always #10 pclk = ~pclk;

    scw_sysref_window dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sysref_in(sysref_in), .sysref_skew(sysref_skew), .div_phase_in(div_phase_in),
        .sysref_timestamp(sysref_timestamp), .irq(irq));
    scw_sysref_src src (.pclk(pclk), .presetn(presetn), .fire(fire), .req_skew(req_skew),
        .req_phase(req_phase), .sysref_in(sysref_in), .sysref_skew(sysref_skew), .div_phase_in(div_phase_in));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Returns the accept flag above the expected hold/setup byte.
    function automatic logic [8:0] expect_ev(input int ng, input int ps, input int sk);
        int a;
        a = (sk < 0) ? -sk : sk;
        return {!(sk < 0 && a <= ng) && !(sk > 0 && a <= ps), (sk > 0) ? a[3:0] : 4'h0, (sk < 0) ? a[3:0] : 4'h0};
    endfunction

    task give_verdict;
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] v);
        n_tests++;
        if (s !== v) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, v);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, d};
        pstrb <= wstrb;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_mismatch++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge keeps the next setup from reassigning psel in the same time step.
        @(posedge pclk);
    endtask

    task wr(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, r, e);
    endtask

    task rdc(input logic [11:0] idx, input logic [7:0] v);
        apb(1'b0, idx, 8'h00, r, e);
        chk(r, {24'h00_0000, v});
    endtask

    // One SYSREF pulse; returns once status has settled.
    task ev(input int s, input logic [3:0] p);
        fire <= 1'b1;
        req_skew <= s[3:0];
        req_phase <= p;
        @(posedge pclk);
        fire <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic ts(input logic [6:0] d);
        int n;
        wr(IDX_TS_DELAY, {1'b0, d});
        rdc(IDX_TS_DELAY, {1'b0, d});
        // Earlier pulses must leave the delay line, or a new tap could show one of them.
        repeat (TS_DELAY_DEPTH + 2) @(posedge pclk);
        fire <= 1'b1;
        req_skew <= 4'h0;
        @(posedge pclk);
        fire <= 1'b0;
        @(posedge pclk);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (sysref_timestamp !== 1'b1 && n < 200);
        chk(n, d + 2);
        @(posedge pclk);
        chk({31'h0, sysref_timestamp}, 32'h0);
        cnt++;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc(IDX_SKEW_WINDOW, 8'h00);
        rdc(IDX_TS_DELAY, 8'h40);
        rdc(IDX_SETUP_HOLD, 8'h00);
        rdc(IDX_DIV_PHASE, 8'h00);
        wr(IDX_CAPTURE_COUNT, 8'h5a);
        rdc(IDX_CAPTURE_COUNT, 8'h00);
        wstrb = 4'he;
        wr(IDX_SKEW_WINDOW, 8'h0f);
        wstrb = 4'hf;
        rdc(IDX_SKEW_WINDOW, 8'h00);
        apb(1'b0, 12'h0ff, 8'h00, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            ng = seed[3:2];
            ps = seed[1:0];
            sk = $signed(seed[7:4]);
            case (i % 4)
                1: sk = -ng;
                2: sk = ps + 1;
                3: sk = -(ng + 1);
                default: ;
            endcase
            mv = (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'h02 : 8'h04);
            wr(IDX_SKEW_WINDOW, {4'h0, seed[3:0]});
            wr(IDX_CTRL1, mv);
            ev(sk, seed[11:8]);
            wr(IDX_CTRL1, 8'h00);
            x = expect_ev(ng, ps, sk);
            if (x[8] && mv != 8'h00) begin
                cnt++;
                exp_st = x[7:0];
                exp_ph = {4'h0, seed[11:8]};
            end
            rdc(IDX_CAPTURE_COUNT, cnt);
            rdc(IDX_SETUP_HOLD, exp_st);
            rdc(IDX_DIV_PHASE, exp_ph);
            rdc(IDX_SKEW_WINDOW, {4'h0, seed[3:0]});
        end
        wr(IDX_CTRL1, 8'h02);
        repeat (150) @(posedge pclk);
        ts(7'h00);
        ts(7'h01);
        ts(7'h02);
        ts(7'h7f);
        ts(seed[6:0]);
        while (cnt != 8'hff) begin
            ev(0, 4'h0);
            cnt++;
        end
        wr(IDX_CTRL1, 8'h00);
        rdc(IDX_CAPTURE_COUNT, 8'hff);
        wr(IDX_CTRL1, 8'h02);
        ev(0, 4'h0);
        wr(IDX_CTRL1, 8'h00);
        rdc(IDX_CAPTURE_COUNT, 8'h00);
        wr(IDX_SKEW_WINDOW, 8'h00);
        wr(IDX_CTRL1, 8'h02);
        ev(-2, 4'h9);
        wr(IDX_CTRL1, 8'h42);
        ev(3, 4'h1);
        wr(IDX_CTRL1, 8'h40);
        rdc(IDX_CAPTURE_COUNT, 8'h00);
        rdc(IDX_SETUP_HOLD, 8'h00);
        wr(IDX_CTRL1, 8'h02);
        ev(1, 4'h2);
        wr(IDX_CTRL1, 8'h00);
        rdc(IDX_CAPTURE_COUNT, 8'h01);
        rdc(IDX_SETUP_HOLD, 8'h10);
        wr(IDX_IRQ_CLEAR, 8'h07);
        rdc(IDX_IRQ_STATUS, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h02);
        wr(IDX_CTRL1, 8'h02);
        ev(0, 4'h0);
        chk({31'h0, irq}, 32'h0);
        ev(-1, 4'h0);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_CTRL1, 8'h00);
        rdc(IDX_IRQ_STATUS, 8'h03);
        wr(IDX_IRQ_CLEAR, 8'h02);
        chk({31'h0, irq}, 32'h0);
        rdc(IDX_IRQ_STATUS, 8'h01);
        // The clear write lands on the very edge that the capture event is set.
        wr(IDX_CTRL1, 8'h02);
        fire <= 1'b1;
        req_skew <= 4'h0;
        @(posedge pclk);
        fire <= 1'b0;
        wr(IDX_IRQ_CLEAR, 8'h01);
        wr(IDX_CTRL1, 8'h00);
        rdc(IDX_IRQ_STATUS, 8'h01);
        give_verdict();
    end
endmodule
